// file: radio_override_map.vh
`ifndef RADIO_OVERRIDE_MAP_VH
`define RADIO_OVERRIDE_MAP_VH

// Register byte addresses.
`define OFS_POWER_AND_MASK_LOW 16'hDF23
`define OFS_POWER_OR_MASK_HIGH 16'hDF24
`define OFS_POWER_OR_MASK_LOW 16'hDF25
`define OFS_VGA_GAIN_CONTROL 16'hDF26
`define OFS_FRONT_GAIN_MODE_CONTROL 16'hDF27
`define OFS_FRAME_FSM_STATE 16'hDF39
`define OFS_ADC_TEST_HIGH 16'hDF3A
`define OFS_ADC_TEST_LOW 16'hDF3B
`define OFS_DAC_TEST_HIGH 16'hDF3C

// Reset values.
`define RST_POWER_AND_MASK_LOW 7'h7F
`define RST_POWER_OR_MASK_HIGH 8'h00
`define RST_POWER_OR_MASK_LOW 7'h00
`define RST_VGA_GAIN 7'h7F
`define RST_VGA_GAIN_OE 1'h0
`define RST_GAIN_MODE_OVERRIDE 2'h0
`define RST_ADC_CLOCK_DISABLE 1'h0
`define RST_TX_CONVERTER_SOURCE 3'h0
`define RST_DAC_I_OVERRIDE_HIGH 4'h0

// Low power-down group bit positions.
`define BIT_FILTER_CAL_OSC_PD 6
`define BIT_CHARGE_PUMP_PD 5
`define BIT_SYNTH_PD 4
`define BIT_CONVERTER_IN_PD 3
`define BIT_VARIABLE_GAIN_AMP_POWERDOWN 2
`define BIT_RX_BANDPASS_PD 1
`define BIT_FRONT_END_PD 0

// High control group bit positions.
`define BIT_VGA_PEAK_RESET_N 7
`define BIT_GLOBAL_GLOBAL_BIAS_POWERDOWN 6
`define BIT_EXTERNAL_BIAS_SWITCH 5
`define BIT_TX_RX_BUFFER_SELECT 4
`define BIT_PRESCALER_PD 3
`define BIT_AMP_NEG_PATH_PD 2
`define BIT_AMP_POS_PATH_PD 1
`define BIT_TX_CONVERTER_PD 0

// Other field positions.
`define BIT_VGA_GAIN_OE 7
`define BIT_ADC_CLOCK_DISABLE 7
`define GAIN_MODE_OVERRIDE_LSB 2
`define DAC_SOURCE_LSB 4

// Transmit converter source codes.
`define SRC_MODULATOR 3'h0
`define SRC_OVERRIDE 3'h1
`define SRC_ADC_HIGH 3'h2
`define SRC_FILTERED_IQ 3'h3
`define SRC_WHITE_NOISE 3'h4
`define SRC_ADC_LOW 3'h5
`define SRC_RSSI_MAGNITUDE 3'h6
`define SRC_SERIAL_DEBUG 3'h7

// Gain mode code that hands control to automatic gain control.
`define GAIN_MODE_AUTO 2'h0

`endif

// file: mask_apply.v
`timescale 1ns/1ps
`default_nettype none

// Registered AND-then-OR override of a group of automatic control lines.
module mask_apply #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Lines
  input wire [WIDTH-1:0] auto_in,
  input wire [WIDTH-1:0] and_mask,
  input wire [WIDTH-1:0] or_mask,
  input wire [WIDTH-1:0] rst_value,
  output reg [WIDTH-1:0] line_ff
);

  wire [WIDTH-1:0] nxt_line;

  // An all-ones AND mask and an all-zero OR mask pass automatic control through.
  assign nxt_line = (auto_in & and_mask) | or_mask;

  // Reset loads all ones; the reset value port is not used, whatever it is tied to.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_ff <= {WIDTH{1'b1}};
    end else begin
      line_ff <= nxt_line;
    end
  end

endmodule

`default_nettype wire

// file: radio_override_test_regs.v
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "radio_override_map.vh"

module radio_override_test_regs #(
  parameter ADDR_WIDTH = 16
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Register port
  input wire [ADDR_WIDTH-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_ff,
  // Automatic controls from the radio state machines
  input wire [6:0] auto_powerdown_low,
  input wire [7:0] auto_control_high,
  input wire [6:0] agc_vga_gain,
  input wire [1:0] agc_gain_mode,
  input wire [5:0] frame_fsm_state_code,
  // Raw converter samples from the analog side
  input wire [6:0] adc_i_pin,
  input wire [6:0] adc_q_pin,
  // Transmit converter sources, I in the upper half
  input wire [11:0] modulator_iq,
  input wire [11:0] filtered_iq,
  input wire [11:0] white_noise_iq,
  input wire [11:0] rssi_magnitude_iq,
  input wire [11:0] high_speed_serial_debug_iq,
  input wire [1:0] dac_i_override_low,
  input wire [5:0] dac_q_override,
  // Effective low power-down lines
  output wire filter_cal_osc_powerdown,
  output wire charge_pump_powerdown,
  output wire synth_powerdown,
  output wire converter_in_powerdown,
  output wire variable_gain_amp_powerdown,
  output wire rx_bandpass_powerdown,
  output wire front_end_powerdown,
  // Effective high control lines
  output wire vga_peak_reset_n,
  output wire global_bias_powerdown,
  output wire external_bias_switch,
  output wire lo_buffer_enable,
  output wire amp_buffer_enable,
  output wire prescaler_powerdown,
  output wire amp_neg_path_powerdown,
  output wire amp_pos_path_powerdown,
  output wire upmix_powerdown,
  output wire tx_converter_powerdown,
  // Gain in use
  output reg [6:0] vga_gain_used_ff,
  output reg [1:0] gain_mode_status_ff,
  // Converter clock gate and transmit data
  output reg adc_clock_enable_ff,
  output reg [5:0] dac_i_ff,
  output reg [5:0] dac_q_ff
);

  // Software-written state.
  reg [6:0] and_mask_low_ff;
  reg [7:0] or_mask_high_ff;
  reg [6:0] or_mask_low_ff;
  reg vga_gain_oe_ff;
  reg [6:0] vga_gain_manual_ff;
  reg [1:0] gain_mode_override_ff;
  reg adc_clock_disable_ff;
  reg [2:0] tx_converter_source_ff;
  reg [3:0] dac_i_override_high_ff;

  // Two-stage synchronisers for the asynchronous converter samples.
  reg [6:0] adc_i_meta_ff;
  reg [6:0] adc_i_ff;
  reg [6:0] adc_q_meta_ff;
  reg [6:0] adc_q_ff;

  wire [6:0] powerdown_low_line;
  wire [7:0] control_high_line;
  wire converter_enabled;

  wire hit_and_low;
  wire hit_or_high;
  wire hit_or_low;
  wire hit_vga;
  wire hit_gain_mode;
  wire hit_fsm;
  wire hit_adc_high;
  wire hit_adc_low;
  wire hit_dac_high;

  reg [7:0] nxt_rdata;
  reg [6:0] nxt_vga_gain_used;
  reg [1:0] nxt_gain_mode_status;
  reg [5:0] nxt_dac_i;
  reg [5:0] nxt_dac_q;

  // Full address decode, so no alias of the bank answers outside its own addresses.
  assign hit_and_low = (reg_addr == `OFS_POWER_AND_MASK_LOW);
  assign hit_or_high = (reg_addr == `OFS_POWER_OR_MASK_HIGH);
  assign hit_or_low = (reg_addr == `OFS_POWER_OR_MASK_LOW);
  assign hit_vga = (reg_addr == `OFS_VGA_GAIN_CONTROL);
  assign hit_gain_mode = (reg_addr == `OFS_FRONT_GAIN_MODE_CONTROL);
  assign hit_fsm = (reg_addr == `OFS_FRAME_FSM_STATE);
  assign hit_adc_high = (reg_addr == `OFS_ADC_TEST_HIGH);
  assign hit_adc_low = (reg_addr == `OFS_ADC_TEST_LOW);
  assign hit_dac_high = (reg_addr == `OFS_DAC_TEST_HIGH);

  // Register writes. Only defined fields are stored, so reserved bits stay zero.
  // Read-only fields that share a byte with writable ones simply drop the written bits.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      and_mask_low_ff <= `RST_POWER_AND_MASK_LOW;
      or_mask_high_ff <= `RST_POWER_OR_MASK_HIGH;
      or_mask_low_ff <= `RST_POWER_OR_MASK_LOW;
      vga_gain_oe_ff <= `RST_VGA_GAIN_OE;
      vga_gain_manual_ff <= `RST_VGA_GAIN;
      gain_mode_override_ff <= `RST_GAIN_MODE_OVERRIDE;
      adc_clock_disable_ff <= `RST_ADC_CLOCK_DISABLE;
      tx_converter_source_ff <= `RST_TX_CONVERTER_SOURCE;
      dac_i_override_high_ff <= `RST_DAC_I_OVERRIDE_HIGH;
    end else if (reg_wr) begin
      if (hit_and_low) begin
        and_mask_low_ff <= reg_wdata[6:0];
      end
      if (hit_or_high) begin
        or_mask_high_ff <= reg_wdata;
      end
      if (hit_or_low) begin
        or_mask_low_ff <= reg_wdata[6:0];
      end
      if (hit_vga) begin
        vga_gain_oe_ff <= reg_wdata[`BIT_VGA_GAIN_OE];
        vga_gain_manual_ff <= reg_wdata[6:0];
      end
      if (hit_gain_mode) begin
        gain_mode_override_ff <= reg_wdata[`GAIN_MODE_OVERRIDE_LSB+1:`GAIN_MODE_OVERRIDE_LSB];
      end
      if (hit_adc_high) begin
        adc_clock_disable_ff <= reg_wdata[`BIT_ADC_CLOCK_DISABLE];
      end
      if (hit_dac_high) begin
        tx_converter_source_ff <= reg_wdata[`DAC_SOURCE_LSB+2:`DAC_SOURCE_LSB];
        dac_i_override_high_ff <= reg_wdata[3:0];
      end
    end
  end

  // The samples change on the converter clock, so each bit is synchronised on its own.
  // A multi-bit sample may therefore read torn for one cycle; this is a test readback only.
  // Nothing but the second stage reads the first, which keeps metastability out of the logic.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      adc_i_meta_ff <= 7'h00;
      adc_i_ff <= 7'h00;
      adc_q_meta_ff <= 7'h00;
      adc_q_ff <= 7'h00;
    end else begin
      adc_i_meta_ff <= adc_i_pin;
      adc_i_ff <= adc_i_meta_ff;
      adc_q_meta_ff <= adc_q_pin;
      adc_q_ff <= adc_q_meta_ff;
    end
  end

  // Effective power-down and control lines.
  // Both groups reset to all ones, so every power-down line holds its block off during reset.
  mask_apply #(
    .WIDTH(7)
  ) u_low_lines (
    .clk(clk),
    .sys_rst(sys_rst),
    .auto_in(auto_powerdown_low),
    .and_mask(and_mask_low_ff),
    .or_mask(or_mask_low_ff),
    .rst_value(7'h7F),
    .line_ff(powerdown_low_line)
  );

  // The high group has no AND mask in this bank, so automatic values pass unmasked.
  mask_apply #(
    .WIDTH(8)
  ) u_high_lines (
    .clk(clk),
    .sys_rst(sys_rst),
    .auto_in(auto_control_high),
    .and_mask(8'hFF),
    .or_mask(or_mask_high_ff),
    .rst_value(8'hFF),
    .line_ff(control_high_line)
  );

  assign filter_cal_osc_powerdown = powerdown_low_line[`BIT_FILTER_CAL_OSC_PD];
  assign charge_pump_powerdown = powerdown_low_line[`BIT_CHARGE_PUMP_PD];
  assign synth_powerdown = powerdown_low_line[`BIT_SYNTH_PD];
  assign converter_in_powerdown = powerdown_low_line[`BIT_CONVERTER_IN_PD];
  assign variable_gain_amp_powerdown = powerdown_low_line[`BIT_VARIABLE_GAIN_AMP_POWERDOWN];
  assign rx_bandpass_powerdown = powerdown_low_line[`BIT_RX_BANDPASS_PD];
  assign front_end_powerdown = powerdown_low_line[`BIT_FRONT_END_PD];

  assign vga_peak_reset_n = control_high_line[`BIT_VGA_PEAK_RESET_N];
  assign global_bias_powerdown = control_high_line[`BIT_GLOBAL_GLOBAL_BIAS_POWERDOWN];
  assign external_bias_switch = control_high_line[`BIT_EXTERNAL_BIAS_SWITCH];
  assign lo_buffer_enable = ~control_high_line[`BIT_TX_RX_BUFFER_SELECT];
  assign amp_buffer_enable = control_high_line[`BIT_TX_RX_BUFFER_SELECT];
  assign prescaler_powerdown = control_high_line[`BIT_PRESCALER_PD];
  assign amp_neg_path_powerdown = control_high_line[`BIT_AMP_NEG_PATH_PD];
  assign amp_pos_path_powerdown = control_high_line[`BIT_AMP_POS_PATH_PD];
  assign tx_converter_powerdown = control_high_line[`BIT_TX_CONVERTER_PD];
  // The mixers follow the same edge as the two amplifier lines, with no extra delay.
  assign upmix_powerdown = amp_neg_path_powerdown & amp_pos_path_powerdown;

  // The converter counts as enabled while its effective power-down line is low.
  assign converter_enabled = ~converter_in_powerdown;

  // Gain selection. The manual gain applies whenever it is enabled, not only while
  // receiving; software should clear the enable before it hands the gain back.
  // A nonzero gain mode override code doubles as the reported status code.
  always @* begin
    nxt_vga_gain_used = vga_gain_oe_ff ? vga_gain_manual_ff : agc_vga_gain;
    if (gain_mode_override_ff == `GAIN_MODE_AUTO) begin
      nxt_gain_mode_status = agc_gain_mode;
    end else begin
      nxt_gain_mode_status = gain_mode_override_ff;
    end
  end

  // Transmit converter source selection.
  // Test sources do not power the converters up; software must do that through the masks.
  // The two sample sources take the synchronised copies, so they lag the pins by two cycles.
  always @* begin
    case (tx_converter_source_ff)
      `SRC_MODULATOR: begin
        nxt_dac_i = modulator_iq[11:6];
        nxt_dac_q = modulator_iq[5:0];
      end
      `SRC_OVERRIDE: begin
        nxt_dac_i = {dac_i_override_high_ff, dac_i_override_low};
        nxt_dac_q = dac_q_override;
      end
      `SRC_ADC_HIGH: begin
        nxt_dac_i = adc_i_ff[6:1];
        nxt_dac_q = adc_q_ff[6:1];
      end
      `SRC_FILTERED_IQ: begin
        nxt_dac_i = filtered_iq[11:6];
        nxt_dac_q = filtered_iq[5:0];
      end
      `SRC_WHITE_NOISE: begin
        nxt_dac_i = white_noise_iq[11:6];
        nxt_dac_q = white_noise_iq[5:0];
      end
      `SRC_ADC_LOW: begin
        nxt_dac_i = adc_i_ff[5:0];
        nxt_dac_q = adc_q_ff[5:0];
      end
      `SRC_RSSI_MAGNITUDE: begin
        nxt_dac_i = rssi_magnitude_iq[11:6];
        nxt_dac_q = rssi_magnitude_iq[5:0];
      end
      default: begin
        nxt_dac_i = high_speed_serial_debug_iq[11:6];
        nxt_dac_q = high_speed_serial_debug_iq[5:0];
      end
    endcase
  end

  // Datapath outputs are registered so the analog side sees clean levels.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vga_gain_used_ff <= `RST_VGA_GAIN;
      gain_mode_status_ff <= `RST_GAIN_MODE_OVERRIDE;
      adc_clock_enable_ff <= 1'b0;
      dac_i_ff <= 6'h00;
      dac_q_ff <= 6'h00;
    end else begin
      vga_gain_used_ff <= nxt_vga_gain_used;
      gain_mode_status_ff <= nxt_gain_mode_status;
      // Registering the gate keeps decode glitches away from the converter clock.
      adc_clock_enable_ff <= converter_enabled & ~adc_clock_disable_ff;
      dac_i_ff <= nxt_dac_i;
      dac_q_ff <= nxt_dac_q;
    end
  end

  // Read mux. Unmapped addresses read zero.
  // Reads have no side effects, so software may poll the live fields as often as it likes.
  always @* begin
    nxt_rdata = 8'h00;
    if (hit_and_low) begin
      nxt_rdata = {1'b0, and_mask_low_ff};
    end else if (hit_or_high) begin
      nxt_rdata = or_mask_high_ff;
    end else if (hit_or_low) begin
      nxt_rdata = {1'b0, or_mask_low_ff};
    end else if (hit_vga) begin
      nxt_rdata = {vga_gain_oe_ff, vga_gain_used_ff};
    end else if (hit_gain_mode) begin
      nxt_rdata = {4'h0, gain_mode_override_ff, gain_mode_status_ff};
    end else if (hit_fsm) begin
      nxt_rdata = {2'h0, frame_fsm_state_code};
    end else if (hit_adc_high) begin
      nxt_rdata = {adc_clock_disable_ff, adc_i_ff};
    end else if (hit_adc_low) begin
      nxt_rdata = {1'b0, adc_q_ff};
    end else if (hit_dac_high) begin
      nxt_rdata = {1'b0, tx_converter_source_ff, dac_i_override_high_ff};
    end
  end

  // Read data holds the last answer between reads.
  // Holding it costs nothing and lets a slow master take the byte a cycle late.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

endmodule

`default_nettype wire

// file: radio_override_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// Watches the register port and the derived radio lines of the override bank.
module radio_override_chk #(
  parameter ADDR_WIDTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [ADDR_WIDTH-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_ff,
  // Observed state
  input wire logic [5:0] frame_fsm_state_code,
  input wire logic [6:0] vga_gain_used_ff,
  input wire logic [1:0] gain_mode_status_ff,
  input wire logic converter_in_powerdown,
  input wire logic adc_clock_enable_ff,
  // Transmit path lines
  input wire logic amp_neg_path_powerdown,
  input wire logic amp_pos_path_powerdown,
  input wire logic upmix_powerdown,
  input wire logic lo_buffer_enable,
  input wire logic amp_buffer_enable,
  // Automatic high controls
  input wire logic [7:0] auto_control_high
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic mapped = reg_addr inside {16'hDF23, 16'hDF24, 16'hDF25, 16'hDF26, 16'hDF27,
    16'hDF39, 16'hDF3A, 16'hDF3B, 16'hDF3C};
  chk_upmix_both_paths: assert property (
    upmix_powerdown == (amp_neg_path_powerdown && amp_pos_path_powerdown))
    else $error("upmix power-down does not follow both amplifier paths");
  chk_buffer_select: assert property (lo_buffer_enable != amp_buffer_enable)
    else $error("exactly one buffer group must be enabled");
  chk_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata_ff == 8'h00)
    else $error("unmapped read returned nonzero data");
  chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata_ff))
    else $error("read data changed without a read");
  chk_state_read: assert property (
    reg_rd && reg_addr == 16'hDF39 |=> reg_rdata_ff == {2'h0, $past(frame_fsm_state_code)})
    else $error("state readback mismatch");
  chk_vga_gain_read: assert property (
    reg_rd && reg_addr == 16'hDF26 |=> reg_rdata_ff[6:0] == $past(vga_gain_used_ff))
    else $error("gain readback is not the gain in use");
  chk_gain_mode_read: assert property (
    reg_rd && reg_addr == 16'hDF27 |=> reg_rdata_ff[7:4] == 4'h0 &&
    reg_rdata_ff[1:0] == $past(gain_mode_status_ff))
    else $error("gain mode readback mismatch");
  chk_reserved_top: assert property (
    reg_rd && reg_addr inside {16'hDF23, 16'hDF25, 16'hDF3B, 16'hDF3C} |=> !reg_rdata_ff[7])
    else $error("reserved top bit read as one");
  chk_adc_clock_gate: assert property (
    adc_clock_enable_ff |-> !$past(converter_in_powerdown))
    else $error("converter clock runs while converter is powered down");
  chk_select_follows_auto: assert property (
    auto_control_high[4] |=> amp_buffer_enable && !lo_buffer_enable)
    else $error("amplifier buffers not enabled by the automatic select");
  chk_upmix_from_auto: assert property (
    auto_control_high[2] && auto_control_high[1] |=> upmix_powerdown)
    else $error("up-conversion mixers not powered down with both amplifier paths");
endmodule

bind radio_override_test_regs radio_override_chk #(.ADDR_WIDTH(ADDR_WIDTH)) chk_inst (
  .clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata_ff, .frame_fsm_state_code, .vga_gain_used_ff,
  .gain_mode_status_ff, .converter_in_powerdown, .adc_clock_enable_ff, .amp_neg_path_powerdown,
  .amp_pos_path_powerdown, .upmix_powerdown, .lo_buffer_enable, .amp_buffer_enable, .auto_control_high);

`default_nettype wire

// file: radio_front_model.sv
`timescale 1ns/1ps
`default_nettype none

// Radio state machines and analog samples, all derived from one bench pattern.
// Samples stay steady while the pattern holds, so the sample synchronizer settles.
module radio_front_model (
  // Pattern from the bench
  input wire logic [7:0] pat,
  // Automatic controls
  output logic [6:0] auto_powerdown_low,
  output logic [7:0] auto_control_high,
  output logic [6:0] agc_vga_gain,
  output logic [1:0] agc_gain_mode,
  output logic [5:0] frame_fsm_state_code,
  // Samples and transmit sources
  output logic [6:0] adc_i_pin,
  output logic [6:0] adc_q_pin,
  output logic [11:0] modulator_iq,
  output logic [11:0] filtered_iq,
  output logic [11:0] white_noise_iq,
  output logic [11:0] rssi_magnitude_iq,
  output logic [11:0] high_speed_serial_debug_iq,
  output logic [1:0] dac_i_override_low,
  output logic [5:0] dac_q_override
);
  assign auto_powerdown_low = pat[6:0];
  assign auto_control_high = pat;
  assign agc_vga_gain = pat[6:0] ^ 7'h2A;
  assign agc_gain_mode = pat[1:0];
  assign frame_fsm_state_code = pat[5:0];
  assign adc_i_pin = pat[6:0];
  assign adc_q_pin = ~pat[6:0];
  assign modulator_iq = {pat, 4'h0};
  assign filtered_iq = {pat, 4'h3};
  assign white_noise_iq = {pat, 4'h4};
  assign rssi_magnitude_iq = {pat, 4'h6};
  assign high_speed_serial_debug_iq = {pat, 4'h7};
  assign dac_i_override_low = 2'h2;
  assign dac_q_override = 6'h15;
endmodule

`default_nettype wire

// file: radio_override_test_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

module radio_override_test_regs_test;
  logic clk, sys_rst, reg_wr, reg_rd;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, pat;
  int miscompares, samples_checked;
  wire [7:0] reg_rdata_ff, auto_control_high;
  wire [6:0] auto_powerdown_low, agc_vga_gain, adc_i_pin, adc_q_pin, vga_gain_used_ff;
  wire [5:0] frame_fsm_state_code, dac_i_ff, dac_q_ff, dac_q_override;
  wire [1:0] agc_gain_mode, dac_i_override_low, gain_mode_status_ff;
  wire [11:0] modulator_iq, filtered_iq, white_noise_iq, rssi_magnitude_iq, high_speed_serial_debug_iq;
  wire filter_cal_osc_powerdown, charge_pump_powerdown, synth_powerdown, converter_in_powerdown;
  wire variable_gain_amp_powerdown, rx_bandpass_powerdown, front_end_powerdown, vga_peak_reset_n;
  wire global_bias_powerdown, external_bias_switch, lo_buffer_enable, amp_buffer_enable;
  wire prescaler_powerdown, amp_neg_path_powerdown, amp_pos_path_powerdown, upmix_powerdown;
  wire tx_converter_powerdown, adc_clock_enable_ff;
  wire [6:0] low_lines = {filter_cal_osc_powerdown, charge_pump_powerdown, synth_powerdown,
    converter_in_powerdown, variable_gain_amp_powerdown, rx_bandpass_powerdown, front_end_powerdown};
  wire [9:0] high_lines = {vga_peak_reset_n, global_bias_powerdown, external_bias_switch,
    lo_buffer_enable, amp_buffer_enable, prescaler_powerdown, amp_neg_path_powerdown,
    amp_pos_path_powerdown, upmix_powerdown, tx_converter_powerdown};
  logic [15:0] ad [9] = '{16'hDF23, 16'hDF24, 16'hDF25, 16'hDF26, 16'hDF27, 16'hDF39, 16'hDF3A,
    16'hDF3B, 16'hDF3C};
  logic [7:0] rv [9] = '{8'h7F, 8'h00, 8'h00, 8'h2A, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h00};
  logic [7:0] wv [9] = '{8'hFF, 8'hA5, 8'hFF, 8'h95, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] bv [9] = '{8'h7F, 8'hA5, 8'h7F, 8'h95, 8'h0F, 8'h00, 8'h80, 8'h7F, 8'h7F};

  radio_override_test_regs radio_override_test_regs_inst (.clk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata_ff, .auto_powerdown_low, .auto_control_high, .agc_vga_gain,
    .agc_gain_mode, .frame_fsm_state_code, .adc_i_pin, .adc_q_pin, .modulator_iq, .filtered_iq,
    .white_noise_iq, .rssi_magnitude_iq, .high_speed_serial_debug_iq, .dac_i_override_low,
    .dac_q_override, .filter_cal_osc_powerdown, .charge_pump_powerdown, .synth_powerdown,
    .converter_in_powerdown, .variable_gain_amp_powerdown, .rx_bandpass_powerdown,
    .front_end_powerdown, .vga_peak_reset_n, .global_bias_powerdown, .external_bias_switch,
    .lo_buffer_enable, .amp_buffer_enable, .prescaler_powerdown, .amp_neg_path_powerdown,
    .amp_pos_path_powerdown, .upmix_powerdown, .tx_converter_powerdown, .vga_gain_used_ff,
    .gain_mode_status_ff, .adc_clock_enable_ff, .dac_i_ff, .dac_q_ff);
  radio_front_model radio_front_model_inst (.pat, .auto_powerdown_low, .auto_control_high,
    .agc_vga_gain, .agc_gain_mode, .frame_fsm_state_code, .adc_i_pin, .adc_q_pin, .modulator_iq,
    .filtered_iq, .white_noise_iq, .rssi_magnitude_iq, .high_speed_serial_debug_iq,
    .dac_i_override_low, .dac_q_override);

  always #5 clk = ~clk;

  task cmp(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata_ff, exp);
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Expected converter pair for each source, with the model's pattern.
  function logic [11:0] exp_dac(input logic [2:0] s);
    case (s)
      3'h1: return {4'hA, 2'h2, 6'h15};
      3'h2: return {pat[6:1], ~pat[6:1]};
      3'h5: return {pat[5:0], ~pat[5:0]};
      default: return {pat, 1'b0, s};
    endcase
  endfunction
  task test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #100000;
    miscompares++;
    test_done;
  end

  initial begin
    clk = 0; sys_rst = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0; pat = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++) rd(ad[i], rv[i]);
    cmp(low_lines, 7'h00);
    cmp(high_lines, 10'h040);
    $display("reset values done");
    for (int i = 0; i < 9; i++) wr(ad[i], wv[i]);
    wr(16'hDF30, 8'hFF);
    for (int i = 0; i < 9; i++) rd(ad[i], bv[i]);
    rd(16'hDF30, 8'h00);
    cmp(low_lines, 7'h7F);
    cmp(high_lines, 10'h2C9);
    cmp(vga_gain_used_ff, 7'h15);
    $display("write readback done");
    pat <= 8'hFE;
    wr(16'hDF23, 8'h55);
    wr(16'hDF25, 8'h02);
    settle(3);
    cmp(low_lines, 7'h56);
    cmp(high_lines, 10'h3BF);
    cmp(adc_clock_enable_ff, 1'b0);
    wr(16'hDF3A, 8'h00);
    settle(3);
    cmp(adc_clock_enable_ff, 1'b1);
    wr(16'hDF25, 8'h0A);
    wr(16'hDF24, 8'h00);
    settle(3);
    cmp(adc_clock_enable_ff, 1'b0);
    cmp(low_lines, 7'h5E);
    cmp(high_lines, 10'h3BE);
    $display("mask override done");
    wr(16'hDF26, 8'h33);
    rd(16'hDF26, 8'h54);
    cmp(vga_gain_used_ff, 7'h54);
    for (int c = 0; c < 4; c++) begin
      wr(16'hDF27, 8'(c << 2));
      rd(16'hDF27, (c != 0) ? 8'(c * 5) : 8'h02);
      cmp(gain_mode_status_ff, (c != 0) ? 2'(c) : 2'h2);
    end
    rd(16'hDF39, 8'h3E);
    rd(16'hDF3A, 8'h7E);
    rd(16'hDF3B, 8'h01);
    $display("gain and readback done");
    wr(16'hDF24, 8'h00);
    settle(2);
    cmp(tx_converter_powerdown, 1'b0);
    for (int s = 0; s < 8; s++) begin
      wr(16'hDF3C, {1'b0, 3'(s), 4'hA});
      settle(2);
      cmp({dac_i_ff, dac_q_ff}, exp_dac(3'(s)));
      rd(16'hDF3C, {1'b0, 3'(s), 4'hA});
    end
    $display("converter source done");
    test_done;
  end
endmodule

`default_nettype wire
